// >>> rtl/gate_select_defines.vh
// register offsets, field positions, reset values for the gate input select block
`ifndef GATE_SELECT_DEFINES_VH
`define GATE_SELECT_DEFINES_VH
// register indices on the plain register port
`define GSEL_ADDR_LOW 2'h0
`define GSEL_ADDR_HIGH 2'h1
`define GSEL_ADDR_POL 2'h2
`define GSEL_ADDR_OUT 2'h3
// reset values
`define GSEL_LOW_RST 16'h0000
`define GSEL_HIGH_RST 16'h0000
`define GSEL_POL_RST 4'h0
// field positions inside a select register
`define GSEL_LOWER_LSB 0
`define GSEL_UPPER_LSB 8
`define GSEL_FIELD_W 8
`define GSEL_POL_W 4
// bit positions inside one gate's enable byte, source 1 lowest pair
`define GSEL_SRC1_INV 0
`define GSEL_SRC1_TRUE 1
`define GSEL_SRC2_INV 2
`define GSEL_SRC2_TRUE 3
`define GSEL_SRC3_INV 4
`define GSEL_SRC3_TRUE 5
`define GSEL_SRC4_INV 6
`define GSEL_SRC4_TRUE 7
// bit positions of the gate invert controls in the polarity word
`define GSEL_POL_G1 0
`define GSEL_POL_G2 1
`define GSEL_POL_G3 2
`define GSEL_POL_G4 3
// read data reset value
`define GSEL_RDATA_RST 16'h0000
`endif

// >>> rtl/input_gate.v
// one input gate: or of enabled true and inverted sources, then polarity
`timescale 1ns/10ps
module input_gate #(
   parameter SRC_N = 4
) (
   // source signals, source 1 in bit 0
   input wire [SRC_N-1:0] src,
   // enables, pair per source: bit 2k+1 true, bit 2k inverted
   input wire [2*SRC_N-1:0] en,
   // gate polarity control
   input wire invert,
   // gated result toward the logic function
   output wire gate_out
);
   // candidate terms, true and complemented per source
   wire [2*SRC_N-1:0] cand;
   genvar k;
   generate
      for (k = 0; k < SRC_N; k = k + 1) begin : g_src
         assign cand[2*k+1] = src[k];
         assign cand[2*k] = ~src[k];
      end
   endgenerate
   // enabled terms only; or of terms; empty is zero
   wire or_res = |(cand & en);
   assign gate_out = or_res ^ invert;
endmodule

// >>> rtl/gate_input_select.v
// gate input select matrix with its register bank
// Contract
// - gate1 enables from low register bits 7:0
// - gate2 enables from low register bits 15:8
// - gate3 enables from high register bits 7:0
// - gate4 enables from high register bits 15:8
// - true enable passes source, else ignored
// - inverted enable passes complement, else ignored
// - each source offers true and inverse
// - gate ors all its enabled candidates
// - polarity bit inverts gate result
`timescale 1ns/10ps
`include "gate_select_defines.vh"
module gate_input_select #(
   parameter SRC_N = 4,
   parameter GATE_N = 4
) (
   clk,
   nrst,
   addr,
   wdata,
   wr,
   rd,
   rdata,
   src,
   gate_out
);
   input wire clk; // system clock
   input wire nrst; // synchronous reset, active low
   input wire [1:0] addr; // register index
   input wire [15:0] wdata; // write data
   input wire wr; // write strobe
   input wire rd; // read strobe
   output reg [15:0] rdata; // read data, one cycle after rd
   input wire [SRC_N-1:0] src; // data source selector outputs
   output wire [GATE_N-1:0] gate_out; // gate outputs after polarity

   // select and polarity registers with their next values
   reg [15:0] gate_select_low_q; // gate1 and gate2 enable bytes
   reg [15:0] gate_select_low_d; // next value of gate_select_low
   reg [15:0] gate_select_high_q; // gate3 and gate4 enable bytes
   reg [15:0] gate_select_high_d; // next value of gate_select_high
   reg [`GSEL_POL_W-1:0] gate_invert_q; // gate1..4 invert in bits 0..3
   reg [`GSEL_POL_W-1:0] gate_invert_d; // next value of the polarity word
   reg [15:0] rdata_d; // read mux, registered into rdata
   // write strobes decoded per register index
   wire wr_low; // write aimed at gate_select_low
   wire wr_high; // write aimed at gate_select_high
   wire wr_pol; // write aimed at the polarity word
   // enable bytes handed to the gates, gate1 lowest byte
   wire [4*`GSEL_FIELD_W-1:0] en_all;

   // named enable fields, one wire per select bit
   // gate1 enable fields
   wire gate1_src1_inv_en = gate_select_low_q[`GSEL_LOWER_LSB + `GSEL_SRC1_INV];
   wire gate1_src1_true_en = gate_select_low_q[`GSEL_LOWER_LSB + `GSEL_SRC1_TRUE];
   wire gate1_src2_inv_en = gate_select_low_q[`GSEL_LOWER_LSB + `GSEL_SRC2_INV];
   wire gate1_src2_true_en = gate_select_low_q[`GSEL_LOWER_LSB + `GSEL_SRC2_TRUE];
   wire gate1_src3_inv_en = gate_select_low_q[`GSEL_LOWER_LSB + `GSEL_SRC3_INV];
   wire gate1_src3_true_en = gate_select_low_q[`GSEL_LOWER_LSB + `GSEL_SRC3_TRUE];
   wire gate1_src4_inv_en = gate_select_low_q[`GSEL_LOWER_LSB + `GSEL_SRC4_INV];
   wire gate1_src4_true_en = gate_select_low_q[`GSEL_LOWER_LSB + `GSEL_SRC4_TRUE];

   wire gate2_src1_inv_en = gate_select_low_q[`GSEL_UPPER_LSB + `GSEL_SRC1_INV];
   wire gate2_src1_true_en = gate_select_low_q[`GSEL_UPPER_LSB + `GSEL_SRC1_TRUE];
   wire gate2_src2_inv_en = gate_select_low_q[`GSEL_UPPER_LSB + `GSEL_SRC2_INV];
   wire gate2_src2_true_en = gate_select_low_q[`GSEL_UPPER_LSB + `GSEL_SRC2_TRUE];
   wire gate2_src3_inv_en = gate_select_low_q[`GSEL_UPPER_LSB + `GSEL_SRC3_INV];
   wire gate2_src3_true_en = gate_select_low_q[`GSEL_UPPER_LSB + `GSEL_SRC3_TRUE];
   wire gate2_src4_inv_en = gate_select_low_q[`GSEL_UPPER_LSB + `GSEL_SRC4_INV];
   wire gate2_src4_true_en = gate_select_low_q[`GSEL_UPPER_LSB + `GSEL_SRC4_TRUE];

   wire gate3_src1_inv_en = gate_select_high_q[`GSEL_LOWER_LSB + `GSEL_SRC1_INV];
   wire gate3_src1_true_en = gate_select_high_q[`GSEL_LOWER_LSB + `GSEL_SRC1_TRUE];
   wire gate3_src2_inv_en = gate_select_high_q[`GSEL_LOWER_LSB + `GSEL_SRC2_INV];
   wire gate3_src2_true_en = gate_select_high_q[`GSEL_LOWER_LSB + `GSEL_SRC2_TRUE];
   wire gate3_src3_inv_en = gate_select_high_q[`GSEL_LOWER_LSB + `GSEL_SRC3_INV];
   wire gate3_src3_true_en = gate_select_high_q[`GSEL_LOWER_LSB + `GSEL_SRC3_TRUE];
   wire gate3_src4_inv_en = gate_select_high_q[`GSEL_LOWER_LSB + `GSEL_SRC4_INV];
   wire gate3_src4_true_en = gate_select_high_q[`GSEL_LOWER_LSB + `GSEL_SRC4_TRUE];

   wire gate4_src1_inv_en = gate_select_high_q[`GSEL_UPPER_LSB + `GSEL_SRC1_INV];
   wire gate4_src1_true_en = gate_select_high_q[`GSEL_UPPER_LSB + `GSEL_SRC1_TRUE];
   wire gate4_src2_inv_en = gate_select_high_q[`GSEL_UPPER_LSB + `GSEL_SRC2_INV];
   wire gate4_src2_true_en = gate_select_high_q[`GSEL_UPPER_LSB + `GSEL_SRC2_TRUE];
   wire gate4_src3_inv_en = gate_select_high_q[`GSEL_UPPER_LSB + `GSEL_SRC3_INV];
   wire gate4_src3_true_en = gate_select_high_q[`GSEL_UPPER_LSB + `GSEL_SRC3_TRUE];
   wire gate4_src4_inv_en = gate_select_high_q[`GSEL_UPPER_LSB + `GSEL_SRC4_INV];
   wire gate4_src4_true_en = gate_select_high_q[`GSEL_UPPER_LSB + `GSEL_SRC4_TRUE];

   wire [`GSEL_FIELD_W-1:0] gate1_en = {gate1_src4_true_en, gate1_src4_inv_en,
      gate1_src3_true_en, gate1_src3_inv_en, gate1_src2_true_en, gate1_src2_inv_en,
      gate1_src1_true_en, gate1_src1_inv_en};

   wire [`GSEL_FIELD_W-1:0] gate2_en = {gate2_src4_true_en, gate2_src4_inv_en,
      gate2_src3_true_en, gate2_src3_inv_en, gate2_src2_true_en, gate2_src2_inv_en,
      gate2_src1_true_en, gate2_src1_inv_en};

   wire [`GSEL_FIELD_W-1:0] gate3_en = {gate3_src4_true_en, gate3_src4_inv_en,
      gate3_src3_true_en, gate3_src3_inv_en, gate3_src2_true_en, gate3_src2_inv_en,
      gate3_src1_true_en, gate3_src1_inv_en};

   wire [`GSEL_FIELD_W-1:0] gate4_en = {gate4_src4_true_en, gate4_src4_inv_en,
      gate4_src3_true_en, gate4_src3_inv_en, gate4_src2_true_en, gate4_src2_inv_en,
      gate4_src1_true_en, gate4_src1_inv_en};

   // all enable bytes side by side, gate1 in the lowest byte
   assign en_all = {gate4_en, gate3_en, gate2_en, gate1_en};

   wire gate1_invert = gate_invert_q[`GSEL_POL_G1]; // gate1 result inverted
   wire gate2_invert = gate_invert_q[`GSEL_POL_G2]; // gate2 result inverted
   wire gate3_invert = gate_invert_q[`GSEL_POL_G3]; // gate3 result inverted
   wire gate4_invert = gate_invert_q[`GSEL_POL_G4]; // gate4 result inverted
   // invert controls side by side, gate1 in bit 0
   wire [3:0] invert_all = {gate4_invert, gate3_invert, gate2_invert, gate1_invert};

   // write decode; index 3 is the read-only status word and is never written
   assign wr_low = wr && (addr == `GSEL_ADDR_LOW);
   assign wr_high = wr && (addr == `GSEL_ADDR_HIGH);
   assign wr_pol = wr && (addr == `GSEL_ADDR_POL);

   // next value of the low select word: hold unless written
   always @* begin
      // hold the stored word
      gate_select_low_d = gate_select_low_q;
      if (wr_low) begin
         gate_select_low_d = wdata;
      end
   end

   // next value of the high select word: hold unless written
   always @* begin
      // hold the stored word
      gate_select_high_d = gate_select_high_q;
      if (wr_high) begin
         gate_select_high_d = wdata;
      end
   end

   // next value of the polarity word: only its low bits are kept
   always @* begin
      // hold the stored controls
      gate_invert_d = gate_invert_q;
      if (wr_pol) begin
         gate_invert_d = wdata[`GSEL_POL_W-1:0];
      end
   end

   // select and polarity registers, synchronous reset
   always @(posedge clk) begin
      if (!nrst) begin
         // power-on values: every gate empty and not inverted
         gate_select_low_q <= `GSEL_LOW_RST;
         gate_select_high_q <= `GSEL_HIGH_RST;
         gate_invert_q <= `GSEL_POL_RST;
      end else begin
         // take next values; a refused write leaves all words as they are
         gate_select_low_q <= gate_select_low_d;
         gate_select_high_q <= gate_select_high_d;
         gate_invert_q <= gate_invert_d;
      end
   end

   // read mux; the status word shows the live gate outputs
   always @* begin
      case (addr)
         `GSEL_ADDR_LOW: begin
            rdata_d = gate_select_low_q;
         end
         `GSEL_ADDR_HIGH: begin
            rdata_d = gate_select_high_q;
         end
         `GSEL_ADDR_POL: begin
            rdata_d = {12'h000, gate_invert_q};
         end
         `GSEL_ADDR_OUT: begin
            rdata_d = {12'h000, gate_out};
         end
         default: begin
            // cannot occur with a two-bit index
            rdata_d = 16'h0000;
         end
      endcase
   end

   // read data register: stands one cycle after rd, zero otherwise
   always @(posedge clk) begin
      if (!nrst) begin
         rdata <= `GSEL_RDATA_RST;
      end else if (rd) begin
         // answer the read taken on this edge
         rdata <= rdata_d;
      end else begin
         // idle bus reads as zero so a stale word is never seen
         rdata <= 16'h0000;
      end
   end

   // one gate per enable byte; the or and polarity live in input_gate
   genvar g;
   generate
      for (g = 0; g < GATE_N; g = g + 1) begin : g_gate
         input_gate #(
            .SRC_N(SRC_N)
         ) u_gate (
            .src(src),
            .en(en_all[g*`GSEL_FIELD_W +: `GSEL_FIELD_W]),
            .invert(invert_all[g]),
            .gate_out(gate_out[g])
         );
      end
   endgenerate
endmodule

// >>> bench/gsel_sva.sv
// port checker for the gate input select block
`timescale 1ns/10ps
module gsel_sva #(parameter SRC_N = 4, parameter GATE_N = 4) (
   input wire clk,
   input wire nrst,
   input wire [1:0] addr,
   input wire [15:0] wdata,
   input wire wr,
   input wire rd,
   input wire [15:0] rdata,
   input wire [SRC_N-1:0] src,
   input wire [GATE_N-1:0] gate_out
);
   reg [15:0] lo_q, hi_q; // shadow selects
   reg [3:0] pl_q; // shadow polarity
   wire [7:0] c = {src[3], ~src[3], src[2], ~src[2], src[1], ~src[1], src[0], ~src[0]};
   // shadows follow register writes
   always @(posedge clk) begin
      if (!nrst) {lo_q, hi_q, pl_q} <= 36'h0;
      else if (wr && addr == 2'h0) lo_q <= wdata;
      else if (wr && addr == 2'h1) hi_q <= wdata;
      else if (wr && addr == 2'h2) pl_q <= wdata[3:0];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_rd;
      rd && addr == 2'h0;
   endsequence
   sequence s_no_rd;
      !rd;
   endsequence
   AST_G1: assert property (gate_out[0] == (|(lo_q[7:0] & c) ^ pl_q[0]))
      else $error("gate1 wrong");
   AST_G2: assert property (gate_out[1] == (|(lo_q[15:8] & c) ^ pl_q[1]))
      else $error("gate2 wrong");
   AST_G3: assert property (gate_out[2] == (|(hi_q[7:0] & c) ^ pl_q[2]))
      else $error("gate3 wrong");
   AST_G4: assert property (gate_out[3] == (|(hi_q[15:8] & c) ^ pl_q[3]))
      else $error("gate4 wrong");
   AST_TRUE: assert property (lo_q[7:0] == 8'h02 |-> gate_out[0] == (src[0] ^ pl_q[0]))
      else $error("true enable");
   AST_INV: assert property (lo_q[7:0] == 8'h01 |-> gate_out[0] == (!src[0] ^ pl_q[0]))
      else $error("inverted enable");
   AST_NONE: assert property (lo_q[15:8] == 8'h00 |-> gate_out[1] == pl_q[1])
      else $error("empty gate");
   AST_RD: assert property (s_rd |=> rdata == $past(lo_q))
      else $error("readback");
   AST_RDZ: assert property (s_no_rd |=> rdata == 16'h0000)
      else $error("read data not idle");
   AST_OR: assert property (hi_q[7:0] == 8'hFF |-> gate_out[2] == !pl_q[2])
      else $error("full gate");
   AST_POL: assert property (lo_q[15:8] == 8'h00 && pl_q[1] |-> gate_out[1])
      else $error("gate polarity");
endmodule
bind gate_input_select gsel_sva #(.SRC_N(SRC_N), .GATE_N(GATE_N)) chk_u (.clk, .nrst,
   .addr, .wdata, .wr, .rd, .rdata, .src, .gate_out);

// >>> bench/testbench.sv
// register and gate bench for the gate input select block
`timescale 1ns/10ps
`include "gate_select_defines.vh"
module testbench;
   reg clk = 0, nrst = 0, wr = 0, rd = 0;
   reg [1:0] addr = 0;
   reg [15:0] wdata = 0, w;
   reg [3:0] ex; // expected gate outputs
   reg [3:0] src = 0;
   wire [15:0] rdata;
   wire [3:0] gate_out;
   integer n_mismatch = 0, compares = 0, i, s;
   gate_input_select dut_u (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .src, .gate_out);
   initial forever #50 clk = ~clk;
   task cmp(input [15:0] g, input [15:0] x); begin
      compares = compares + 1;
      if (g !== x) begin
         n_mismatch = n_mismatch + 1;
         $display("BAD %0t %h %h", $time, g, x);
      end
   end endtask
   // expected gate outputs from select words, polarity and source levels
   function [3:0] exp_gates(input [15:0] lo, input [15:0] hi, input [3:0] pol,
      input [3:0] sv);
      reg [31:0] bytes;
      integer g, k;
      begin
         bytes = {hi, lo};
         exp_gates = 4'h0;
         for (g = 0; g < 4; g = g + 1) begin
            for (k = 0; k < 4; k = k + 1) begin
               if (bytes[g*8+2*k+1] && sv[k]) exp_gates[g] = 1'b1;
               if (bytes[g*8+2*k] && !sv[k]) exp_gates[g] = 1'b1;
            end
            exp_gates[g] = exp_gates[g] ^ pol[g];
         end
      end
   endfunction
   task wreg(input [1:0] a, input [15:0] d); begin
      @(posedge clk); addr <= a; wdata <= d; wr <= 1;
      @(posedge clk); wr <= 0;
   end endtask
   task rreg(input [1:0] a, input [15:0] x); begin
      @(posedge clk); addr <= a; rd <= 1;
      @(posedge clk); rd <= 0;
      @(negedge clk); cmp(rdata, x);
   end endtask
   task give_verdict; begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   end endtask
   // hang guard
   initial begin
      #1000000 n_mismatch = n_mismatch + 1;
      give_verdict;
   end
   initial begin
      repeat (4) @(posedge clk);
      nrst <= 1;
      rreg(`GSEL_ADDR_LOW, `GSEL_LOW_RST);
      rreg(`GSEL_ADDR_HIGH, `GSEL_HIGH_RST);
      // each single enable of gate1 and gate2, all source values
      for (i = 0; i < 16; i = i + 1) begin
         w = 16'h0001 << i;
         wreg(`GSEL_ADDR_LOW, w);
         wreg(`GSEL_ADDR_HIGH, ~w);
         wreg(`GSEL_ADDR_POL, i[15:0]);
         rreg(`GSEL_ADDR_HIGH, ~w);
         for (s = 0; s < 16; s = s + 1) begin
            @(posedge clk) src <= s[3:0];
            ex = exp_gates(w, ~w, i[3:0], s[3:0]);
            @(negedge clk) cmp({12'h000, gate_out}, {12'h000, ex});
         end
      end
      wreg(`GSEL_ADDR_LOW, 16'h0000);
      wreg(`GSEL_ADDR_HIGH, 16'h0000);
      wreg(`GSEL_ADDR_POL, 16'h0005);
      @(negedge clk); cmp({12'h000, gate_out}, 16'h0005);
      rreg(`GSEL_ADDR_POL, 16'h0005);
      rreg(`GSEL_ADDR_OUT, 16'h0005);
      wreg(`GSEL_ADDR_OUT, 16'hFFFF);
      rreg(`GSEL_ADDR_LOW, 16'h0000);
      @(negedge clk); cmp(rdata, 16'h0000);
      give_verdict;
   end
endmodule
